// [logic/smc_core_end.sv]
// CPU-core end: software register port, sleep instruction and wake sources onto the link
`timescale 1ns/100ps
`default_nettype none
`include "smc_cfg.svh"
module smc_core_end #(
  parameter bit AUTO_CLR_EN = 1'b1
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  smc_if.core                         bus,
  input  wire logic [`SMC_ADDR_W-1:0] sw_addr_in,
  input  wire logic                   sw_wr_in,
  input  wire logic                   sw_rd_in,
  input  wire logic [`SMC_CTRL_W-1:0] sw_wdata_in,
  output logic      [`SMC_CTRL_W-1:0] sw_rdata_out,
  input  wire logic                   sleep_exec_in,
  input  wire logic                   async_sel_in,
  input  wire logic                   gie_in,
  input  wire logic                   t2_ie_in,
  input  wire logic                   irq_any_in,
  input  wire logic                   adc_done_in,
  input  wire logic                   twi_match_in,
  input  wire logic                   t2_irq_in,
  input  wire logic                   nvm_rdy_in,
  input  wire logic                   ext_lvl01_in,
  input  wire logic                   ext_irq2_in,
  input  wire logic                   rst_req_in,
  output logic                        isr_enter_out,
  output logic                        reset_vec_out,
  output logic                        cpu_clk_run_out
);
  import smc_pkg::*;

  logic      wr_r, wr_nxt;
  smc_ctrl_t wd_r, wd_nxt;
  smc_ctrl_t rd_r, rd_nxt;
  logic      slp_r, isr_r, rvec_r, run_r;
  logic [9:0] src_r;
  smc_ctrl_t wsel;

  // Mode 011 without the async clock would leave timer state undefined
  always_comb begin
    wsel = sw_wdata_in;
    if (!async_sel_in &&
        {wsel[`SMC_MSEL2_BIT], wsel[`SMC_MSEL1_BIT], wsel[`SMC_MSEL0_BIT]} == `SMC_MODE_PSAVE) begin
      wsel[`SMC_MSEL0_BIT] = 1'b0;
    end
  end

  always_comb begin
    wr_nxt = 1'b0;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    if (sw_wr_in && sw_addr_in == `SMC_ADDR_CTRL) begin
      wr_nxt = 1'b1;
      wd_nxt = wsel;
    end else if (AUTO_CLR_EN && (bus.wake_irq || bus.wake_rst)) begin
      wr_nxt = 1'b1;
      wd_nxt = bus.ctrl_q;
      wd_nxt[`SMC_SLPEN_BIT] = 1'b0;
    end
    if (sw_rd_in) begin
      rd_nxt = '0;
      if (sw_addr_in == `SMC_ADDR_CTRL) begin
        rd_nxt = bus.ctrl_q;
      end else if (sw_addr_in == `SMC_ADDR_STAT) begin
        rd_nxt[`SMC_STAT_HALT]  = bus.cpu_halt;
        rd_nxt[`SMC_STAT_SLEEP] = bus.sleeping;
      end
    end
  end

  // Sources are sampled once; level wake lines rely on the source holding them
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_r   <= 1'b0;
      wd_r   <= `SMC_CTRL_RST;
      rd_r   <= '0;
      slp_r  <= 1'b0;
      isr_r  <= 1'b0;
      rvec_r <= 1'b0;
      run_r  <= 1'b1;
      src_r  <= '0;
    end else begin
      wr_r   <= wr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      slp_r  <= sleep_exec_in;
      isr_r  <= bus.wake_irq;
      rvec_r <= bus.wake_rst;
      run_r  <= ~bus.gate[`SMC_G_CPU];
      src_r  <= {rst_req_in, ext_irq2_in, ext_lvl01_in, nvm_rdy_in, t2_irq_in,
                 twi_match_in, adc_done_in, irq_any_in, t2_ie_in, gie_in};
    end
  end

  assign bus.ctrl_wr    = wr_r;
  assign bus.ctrl_wdata = wd_r;
  assign bus.sleep_exec = slp_r;
  assign bus.async_sel  = async_sel_in;
  assign bus.gie        = src_r[0];
  assign bus.t2_ie      = src_r[1];
  assign bus.irq_any    = src_r[2];
  assign bus.adc_done   = src_r[3];
  assign bus.twi_match  = src_r[4];
  assign bus.t2_irq     = src_r[5];
  assign bus.nvm_rdy    = src_r[6];
  assign bus.ext_lvl01  = src_r[7];
  assign bus.ext_irq2   = src_r[8];
  assign bus.rst_req    = src_r[9];
  assign sw_rdata_out   = rd_r;
  assign isr_enter_out  = isr_r;
  assign reset_vec_out  = rvec_r;
  assign cpu_clk_run_out = run_r;
endmodule // smc_core_end
`default_nettype wire

// [logic/smc_sleep_ctrl.sv]
// Sleep-mode controller: mode register, clock gating, wake selection and wake timing
`timescale 1ns/100ps
`default_nettype none
`include "smc_cfg.svh"
module smc_sleep_ctrl #(
  parameter int STARTUP_CK = `SMC_STARTUP_CK
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  smc_if.dev        bus,
  input  wire logic xtal_sel_in,
  input  wire logic adc_en_in,
  output logic      osc_off_out,
  output logic      adc_start_out,
  output logic      sleeping_out
);
  import smc_pkg::*;

  localparam smc_cnt_t START_CNT = smc_cnt_t'(STARTUP_CK - 1);
  localparam smc_cnt_t STBY_CNT  = smc_cnt_t'(`SMC_STANDBY_CK - 1);
  localparam smc_cnt_t HALT_CNT  = smc_cnt_t'(`SMC_HALT_CK - 1);

  smc_state_t st_r, st_nxt;
  smc_cnt_t   cnt_r, cnt_nxt;
  smc_mode_t  mode_r, mode_nxt;
  smc_ctrl_t  ctrl_r, ctrl_nxt;
  smc_gate_t  gate_r, gate_nxt;
  logic       osc_off_r, osc_off_nxt;
  logic       halt_r, halt_nxt;
  logic       sleep_r, sleep_nxt;
  logic       wake_irq_r, wake_irq_nxt;
  logic       wake_rst_r, wake_rst_nxt;
  logic       adc_start_r, adc_start_nxt;
  smc_mode_t  sel_mode;
  logic       sel_valid;
  logic       wake_hit;

  // Mode code spread over non-adjacent bits of the control register
  assign sel_mode = {ctrl_r[`SMC_MSEL2_BIT], ctrl_r[`SMC_MSEL1_BIT], ctrl_r[`SMC_MSEL0_BIT]};

  // Standby codes need a crystal; codes 100/101 are never entered
  always_comb begin
    unique case (sel_mode)
      `SMC_MODE_IDLE, `SMC_MODE_QUIET, `SMC_MODE_PDOWN, `SMC_MODE_PSAVE: sel_valid = 1'b1;
      `SMC_MODE_STBY, `SMC_MODE_XSTBY: sel_valid = xtal_sel_in;
      default: sel_valid = 1'b0;
    endcase
  end

  // Domains stopped per mode; a set bit stops that clock
  function automatic smc_gate_t gates_for(input smc_mode_t m, input logic asy_run);
    smc_gate_t g;
    g = `SMC_GATE_ALL;
    unique case (m)
      `SMC_MODE_IDLE: begin
        g = `SMC_GATE_NONE;
        g[`SMC_G_CPU] = 1'b1;
        g[`SMC_G_FLASH] = 1'b1;
      end
      `SMC_MODE_QUIET: begin
        g = `SMC_GATE_NONE;
        g[`SMC_G_CPU] = 1'b1;
        g[`SMC_G_FLASH] = 1'b1;
        g[`SMC_G_IO] = 1'b1;
      end
      `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: g[`SMC_G_ASY] = ~asy_run;
      default: g = `SMC_GATE_ALL;
    endcase
    return g;
  endfunction

  // Wake sources accepted by the mode being slept in
  always_comb begin
    unique case (mode_r)
      `SMC_MODE_IDLE: wake_hit = bus.irq_any;
      `SMC_MODE_QUIET: wake_hit = bus.adc_done | bus.twi_match | bus.t2_irq | bus.nvm_rdy
                                  | bus.ext_lvl01 | bus.ext_irq2;
      `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: wake_hit = bus.twi_match | bus.ext_lvl01 | bus.ext_irq2
                                  | (bus.t2_irq & bus.t2_ie & bus.gie & bus.async_sel);
      default: wake_hit = bus.twi_match | bus.ext_lvl01 | bus.ext_irq2;
    endcase
  end

  always_comb begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    mode_nxt      = mode_r;
    ctrl_nxt      = ctrl_r;
    gate_nxt      = gate_r;
    osc_off_nxt   = osc_off_r;
    halt_nxt      = halt_r;
    sleep_nxt     = sleep_r;
    wake_irq_nxt  = 1'b0;
    wake_rst_nxt  = 1'b0;
    adc_start_nxt = 1'b0;
    if (bus.ctrl_wr) begin
      ctrl_nxt = bus.ctrl_wdata & `SMC_CTRL_MASK;
    end
    unique case (st_r)
      SMC_RUN: begin
        if (bus.sleep_exec && ctrl_r[`SMC_SLPEN_BIT] && sel_valid) begin
          st_nxt      = SMC_SLEEP;
          mode_nxt    = sel_mode;
          gate_nxt    = gates_for(sel_mode, bus.async_sel);
          osc_off_nxt = (sel_mode == `SMC_MODE_PDOWN) || (sel_mode == `SMC_MODE_PSAVE);
          halt_nxt    = 1'b1;
          sleep_nxt   = 1'b1;
          adc_start_nxt = adc_en_in && ((sel_mode == `SMC_MODE_IDLE) ||
                                        (sel_mode == `SMC_MODE_QUIET));
        end
      end
      SMC_SLEEP: begin
        // Storage is only clock-gated, never cleared, so its contents survive
        if (bus.rst_req) begin
          st_nxt       = SMC_RUN;
          gate_nxt     = `SMC_GATE_NONE;
          osc_off_nxt  = 1'b0;
          halt_nxt     = 1'b0;
          sleep_nxt    = 1'b0;
          wake_rst_nxt = 1'b1;
        end else if (wake_hit) begin
          osc_off_nxt = 1'b0;
          sleep_nxt   = 1'b0;
          if ((mode_r == `SMC_MODE_IDLE) || (mode_r == `SMC_MODE_QUIET)) begin
            st_nxt   = SMC_HALT;
            cnt_nxt  = HALT_CNT;
            gate_nxt = `SMC_GATE_NONE;
          end else begin
            st_nxt  = SMC_START;
            cnt_nxt = (mode_r[2]) ? STBY_CNT : START_CNT;
          end
        end
      end
      SMC_START: begin
        // Clocks stay gated while the oscillator settles
        if (bus.rst_req) begin
          st_nxt       = SMC_RUN;
          gate_nxt     = `SMC_GATE_NONE;
          halt_nxt     = 1'b0;
          wake_rst_nxt = 1'b1;
        end else if (cnt_r == '0) begin
          st_nxt   = SMC_HALT;
          cnt_nxt  = HALT_CNT;
          gate_nxt = `SMC_GATE_NONE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      SMC_HALT: begin
        if (bus.rst_req) begin
          st_nxt       = SMC_RUN;
          halt_nxt     = 1'b0;
          wake_rst_nxt = 1'b1;
        end else if (cnt_r == '0) begin
          st_nxt       = SMC_RUN;
          halt_nxt     = 1'b0;
          wake_irq_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r        <= SMC_RUN;
      cnt_r       <= '0;
      mode_r      <= `SMC_MODE_IDLE;
      ctrl_r      <= `SMC_CTRL_RST;
      gate_r      <= `SMC_GATE_NONE;
      osc_off_r   <= 1'b0;
      halt_r      <= 1'b0;
      sleep_r     <= 1'b0;
      wake_irq_r  <= 1'b0;
      wake_rst_r  <= 1'b0;
      adc_start_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      mode_r      <= mode_nxt;
      ctrl_r      <= ctrl_nxt;
      gate_r      <= gate_nxt;
      osc_off_r   <= osc_off_nxt;
      halt_r      <= halt_nxt;
      sleep_r     <= sleep_nxt;
      wake_irq_r  <= wake_irq_nxt;
      wake_rst_r  <= wake_rst_nxt;
      adc_start_r <= adc_start_nxt;
    end
  end

  assign bus.ctrl_q     = ctrl_r;
  assign bus.gate       = gate_r;
  assign bus.cpu_halt   = halt_r;
  assign bus.sleeping   = sleep_r;
  assign bus.wake_irq   = wake_irq_r;
  assign bus.wake_rst   = wake_rst_r;
  assign osc_off_out    = osc_off_r;
  assign adc_start_out  = adc_start_r;
  assign sleeping_out   = sleep_r;
endmodule // smc_sleep_ctrl
`default_nettype wire

// [pkg/smc_cfg.svh]
// Constants of the sleep-mode controller: field positions, codes, reset values, cycle counts
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_CTRL_W       8
`define SMC_CTRL_RST     8'h00
`define SMC_CTRL_MASK    8'hF0
`define SMC_MSEL2_BIT    7
`define SMC_SLPEN_BIT    6
`define SMC_MSEL1_BIT    5
`define SMC_MSEL0_BIT    4
`define SMC_MODE_IDLE    3'h0
`define SMC_MODE_QUIET   3'h1
`define SMC_MODE_PDOWN   3'h2
`define SMC_MODE_PSAVE   3'h3
`define SMC_MODE_STBY    3'h6
`define SMC_MODE_XSTBY   3'h7
`define SMC_GATE_W       5
`define SMC_G_CPU        0
`define SMC_G_FLASH      1
`define SMC_G_IO         2
`define SMC_G_ADC        3
`define SMC_G_ASY        4
`define SMC_GATE_NONE    5'h00
`define SMC_GATE_ALL     5'h1F
`define SMC_HALT_CK      4
`define SMC_STANDBY_CK   6
`define SMC_STARTUP_CK   6
`define SMC_CNT_W        8
`define SMC_ADDR_W       2
`define SMC_ADDR_CTRL    2'h0
`define SMC_ADDR_STAT    2'h1
`define SMC_STAT_HALT    0
`define SMC_STAT_SLEEP   1
`endif

// [pkg/smc_if.sv]
// Link between the sleep controller and the CPU core with its wake sources
`timescale 1ns/100ps
`default_nettype none
interface smc_if;
  import smc_pkg::*;
  logic      ctrl_wr;
  smc_ctrl_t ctrl_wdata;
  smc_ctrl_t ctrl_q;
  logic      sleep_exec;
  logic      async_sel;
  logic      gie;
  logic      t2_ie;
  logic      irq_any;
  logic      adc_done;
  logic      twi_match;
  logic      t2_irq;
  logic      nvm_rdy;
  logic      ext_lvl01;
  logic      ext_irq2;
  logic      rst_req;
  smc_gate_t gate;
  logic      cpu_halt;
  logic      sleeping;
  logic      wake_irq;
  logic      wake_rst;
  modport dev (input ctrl_wr, ctrl_wdata, sleep_exec, async_sel, gie, t2_ie, irq_any, adc_done,
               twi_match, t2_irq, nvm_rdy, ext_lvl01, ext_irq2, rst_req,
               output ctrl_q, gate, cpu_halt, sleeping, wake_irq, wake_rst);
  modport core (output ctrl_wr, ctrl_wdata, sleep_exec, async_sel, gie, t2_ie, irq_any, adc_done,
                twi_match, t2_irq, nvm_rdy, ext_lvl01, ext_irq2, rst_req,
                input ctrl_q, gate, cpu_halt, sleeping, wake_irq, wake_rst);
endinterface
`default_nettype wire

// [pkg/smc_pkg.sv]
// Types shared by both ends of the sleep-mode controller
`default_nettype none
`include "smc_cfg.svh"
package smc_pkg;
  typedef enum {SMC_RUN, SMC_SLEEP, SMC_START, SMC_HALT} smc_state_t;
  typedef logic [2:0]              smc_mode_t;
  typedef logic [`SMC_GATE_W-1:0]  smc_gate_t;
  typedef logic [`SMC_CTRL_W-1:0]  smc_ctrl_t;
  typedef logic [`SMC_CNT_W-1:0]   smc_cnt_t;
endpackage
`default_nettype wire

// [tb/sleep_mode_controller_tb_top.sv]
// Self-checking bench: sleep controller facing the core end
`timescale 1ns/100ps
`default_nettype none
`include "smc_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module sleep_mode_controller_tb_top;
  import smc_pkg::*;
  // Short start-up keeps power-down and power-save wakes quick
  localparam int SU = 3;
  logic       sys_clk_in = 1'h0;
  logic       rst_in = 1'h1;
  logic [1:0] sw_addr_in = 2'h0;
  logic [7:0] sw_wdata_in = 8'h00;
  logic [7:0] sw_rdata_out;
  logic [2:0] wsrc = 3'h0;
  logic       sw_wr_in = 1'h0, sw_rd_in = 1'h0, sleep_exec_in = 1'h0, async_sel_in = 1'h0, gie_in = 1'h0;
  logic       t2_ie_in = 1'h0, irq_any_in = 1'h0, adc_done_in = 1'h0, t2_irq_in = 1'h0, nvm_rdy_in = 1'h0;
  logic       rst_req_in = 1'h0, xtal_sel_in = 1'h0, adc_en_in = 1'h0;
  logic       osc_off_out, adc_start_out, sleeping_out, isr_enter_out, reset_vec_out, cpu_clk_run_out;
  int         err_count = 0;
  int         checked = 0;
  smc_if lnk ();
  smc_sleep_ctrl #(.STARTUP_CK(SU)) smc_sleep_ctrl_inst (.sys_clk_in, .rst_in, .bus(lnk.dev), .xtal_sel_in,
    .adc_en_in, .osc_off_out, .adc_start_out, .sleeping_out);
  smc_core_end smc_core_end_inst (.sys_clk_in, .rst_in, .bus(lnk.core), .sw_addr_in, .sw_wr_in, .sw_rd_in,
    .sw_wdata_in, .sw_rdata_out, .sleep_exec_in, .async_sel_in, .gie_in, .t2_ie_in, .irq_any_in, .adc_done_in,
    .twi_match_in(wsrc[0]), .t2_irq_in, .nvm_rdy_in, .ext_lvl01_in(wsrc[1]), .ext_irq2_in(wsrc[2]),
    .rst_req_in, .isr_enter_out, .reset_vec_out, .cpu_clk_run_out);
  smc_link_assertions smc_link_assertions_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .ctrl_q(lnk.ctrl_q), .sleep_exec(lnk.sleep_exec), .irq_any(lnk.irq_any), .twi_match(lnk.twi_match),
    .ext_lvl01(lnk.ext_lvl01), .ext_irq2(lnk.ext_irq2), .rst_req(lnk.rst_req), .gate(lnk.gate),
    .cpu_halt(lnk.cpu_halt), .sleeping(lnk.sleeping), .wake_irq(lnk.wake_irq), .wake_rst(lnk.wake_rst));
  always #5 sys_clk_in = ~sys_clk_in;
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    sw_addr_in <= a;
    sw_wdata_in <= d;
    sw_wr_in <= 1'h1;
    tick();
    sw_wr_in <= 1'h0;
  endtask
  // Read data appears in the cycle after the strobe and holds until the next read strobe
  task automatic rd(logic [1:0] a, output logic [7:0] d);
    sw_addr_in <= a;
    sw_rd_in <= 1'h1;
    tick();
    sw_rd_in <= 1'h0;
    @(negedge sys_clk_in);
    d = sw_rdata_out;
    tick();
  endtask
  // Returns mid-cycle so one-cycle pulses are looked at while settled
  task automatic go_sleep();
    sleep_exec_in <= 1'h1;
    tick();
    sleep_exec_in <= 1'h0;
    tick();
    @(negedge sys_clk_in);
  endtask
  task automatic wait_hi(bit rv, output int n);
    for (n = 1; n < 60; n++) begin
      @(negedge sys_clk_in);
      if ((rv ? reset_vec_out : lnk.wake_irq) === 1'h1) break;
      tick();
    end
    tick();
  endtask
  function automatic logic [4:0] exp_gate(int m, bit as);
    case (m)
      0: return 5'h03;
      1: return 5'h07;
      3, 7: return as ? 5'h0F : 5'h1F;
      default: return 5'h1F;
    endcase
  endfunction
  task automatic close_out();
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(5000);
    err_count++;
    close_out();
  end
  initial begin
    int n;
    int sm;
    bit as, xt, ae, ok;
    logic [7:0] d;
    void'($urandom(32'hF7BFE371));
    tick(4);
    rst_in <= 1'h0;
    tick();
    for (int m = 0; m < 8; m++) begin
      as = 1'($urandom % 2);
      xt = (m == 6) ? 1'h1 : 1'($urandom % 2);
      ae = 1'($urandom % 2);
      sm = (m == 3 && !as) ? 2 : m;
      ok = m < 4 || (m > 5 && xt);
      async_sel_in <= as;
      xtal_sel_in <= xt;
      adc_en_in <= ae;
      wr(2'h0, {m[2], 1'h1, m[1:0], 4'($urandom)});
      tick();
      rd(2'h0, d);
      `CHK("ctrl", {sm[2], 1'h1, sm[1:0], 4'h0}, d)
      go_sleep();
      `CHK("gate", ok ? exp_gate(sm, as) : 5'h00, lnk.gate)
      `CHK("osc", ok && sm inside {2, 3}, osc_off_out)
      `CHK("adc", ok && sm < 2 && ae, adc_start_out)
      tick();
      rd(2'h1, d);
      `CHK("stat", ok ? 8'h03 : 8'h00, d)
      `CHK("cpuclk", !ok, cpu_clk_run_out)
      if (ok) begin
        if (m == 0) irq_any_in <= 1'h1;
        else wsrc <= 3'h1 << ($urandom % 3);
        wait_hi(1'h0, n);
        `CHK("lat", 7 + (sm < 2 ? 0 : sm < 4 ? SU : 6), n)
        irq_any_in <= 1'h0;
        wsrc <= 3'h0;
        @(negedge sys_clk_in);
        `CHK("isr", 1'h1, isr_enter_out)
      end
      tick(3);
    end
    wr(2'h0, 8'h00);
    tick();
    go_sleep();
    `CHK("noen", 1'h0, sleeping_out)
    tick();
    wr(2'h2, 8'hF0);
    tick();
    rd(2'h0, d);
    `CHK("unmapped", 8'h00, d)
    rd(2'h2, d);
    `CHK("rsvd", 8'h00, d)
    wr(2'h0, 8'h60);
    tick();
    go_sleep();
    tick();
    {irq_any_in, adc_done_in, t2_irq_in, nvm_rdy_in, gie_in, t2_ie_in} <= 6'h3F;
    tick(10);
    `CHK("ignore", 1'h1, sleeping_out)
    rst_req_in <= 1'h1;
    wait_hi(1'h1, n);
    `CHK("rstvec", 4, n)
    rst_req_in <= 1'h0;
    {irq_any_in, adc_done_in, t2_irq_in, nvm_rdy_in, gie_in, t2_ie_in} <= 6'h00;
    tick(3);
    // Power-save on the async clock: timer event wakes only with both enables
    async_sel_in <= 1'h1;
    wr(2'h0, 8'h70);
    tick();
    go_sleep();
    `CHK("psgate", 5'h0F, lnk.gate)
    tick();
    {t2_irq_in, t2_ie_in, gie_in} <= 3'h6;
    tick(6);
    `CHK("nogie", 1'h1, sleeping_out)
    gie_in <= 1'h1;
    wait_hi(1'h0, n);
    `CHK("t2wake", 7 + SU, n)
    {t2_irq_in, t2_ie_in, gie_in} <= 3'h0;
    tick(3);
    close_out();
  end
endmodule // sleep_mode_controller_tb_top
`default_nettype wire

// [tb/smc_link_assertions.sv]
// Checker on the link between the sleep controller and the core end
`timescale 1ns/100ps
`default_nettype none
module smc_link_assertions (
  input wire logic               sys_clk_in,
  input wire logic               rst_in,
  input wire smc_pkg::smc_ctrl_t ctrl_q,
  input wire logic               sleep_exec,
  input wire logic               irq_any,
  input wire logic               twi_match,
  input wire logic               ext_lvl01,
  input wire logic               ext_irq2,
  input wire logic               rst_req,
  input wire smc_pkg::smc_gate_t gate,
  input wire logic               cpu_halt,
  input wire logic               sleeping,
  input wire logic               wake_irq,
  input wire logic               wake_rst
);
  import smc_pkg::*;
  logic [2:0] mode;
  logic       run;
  logic       take;
  assign mode = {ctrl_q[7], ctrl_q[5:4]};
  assign run  = !sleeping && !cpu_halt;
  assign take = run && sleep_exec && ctrl_q[6];
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_need_en; run && sleep_exec && !ctrl_q[6] |=> !sleeping && gate == 5'h00; endproperty
  a_need_en: assert property (p_need_en) else $error("slept without enable");
  property p_idle_gate; take && mode == 3'h0 |=> gate == 5'h03 && sleeping && cpu_halt; endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle gates");
  property p_quiet_gate; take && mode == 3'h1 |=> gate == 5'h07 && sleeping; endproperty
  a_quiet_gate: assert property (p_quiet_gate) else $error("quiet gates");
  property p_pdown_gate; take && mode == 3'h2 |=> gate == 5'h1F && sleeping; endproperty
  a_pdown_gate: assert property (p_pdown_gate) else $error("power-down gates");
  property p_rsvd; take && mode inside {3'h4, 3'h5} |=> !sleeping && !cpu_halt && gate == 5'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code slept");
  // Four halt cycles, then the handler may run
  property p_idle_wake;
    sleeping && gate == 5'h03 && irq_any && !rst_req |=>
      (gate == 5'h00 && cpu_halt && !sleeping && !wake_irq)[*4] ##1 wake_irq;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake timing");
  property p_stby_wake; sleeping && mode == 3'h6 && twi_match && !rst_req |-> ##11 wake_irq; endproperty
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake timing");
  property p_rst_wake; sleeping && rst_req |=> wake_rst && !cpu_halt && gate == 5'h00; endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset wake");
  property p_pd_hold; sleeping && mode == 3'h2 && !(rst_req || twi_match || ext_lvl01 || ext_irq2) |=> sleeping;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down woke early");
endmodule // smc_link_assertions
`default_nettype wire
